// ---- rtl/ssef_pkg.sv ----
// shared constants and types for the serial status/error flag block
package ssef_pkg;
    // register byte offsets
    localparam logic [11:0] STATUS_ADDR = 12'h000;
    localparam logic [11:0] CTRL_ADDR = 12'h004;
    localparam logic [7:0] STATUS_RESET = 8'h84;
    // status bit positions
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_RX_FULL = 6;
    localparam int BIT_FER_ERS = 4;
    localparam int BIT_PARITY = 3;
    localparam int BIT_TX_END = 2;
    localparam int BIT_RX_MP = 1;
    localparam int BIT_TX_MP = 0;
    localparam int CTRL_WIDTH = 9;
    // smart card end-of-transmit delay, in half bit times
    localparam int GM0_HALF_ETU = 5;
    localparam int GM1_HALF_ETU = 2;
    localparam int ETU_CYCLES_DEF = 16;
    localparam int CNT_WIDTH = 16;

    // control fields, msb first
    typedef struct packed {
        logic smart_card_select;
        logic guard_mode;
        logic sync_mode;
        logic multiproc_en;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic receiver_enable;
        logic transmitter_enable;
    } ssef_ctrl_s;

    // one received character from the framing engine
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity;
        logic stop1;
        logic stop2;
        logic mp;
    } ssef_rx_s;
endpackage

// ---- rtl/ssef_status.sv ----
// serial status register: error flags, transmit end, multiprocessor bits
`timescale 1ns/100ps
`default_nettype none
module ssef_status #(
    parameter int ETU_CYCLES = ssef_pkg::ETU_CYCLES_DEF
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic standby_i,
    input wire ssef_pkg::ssef_rx_s rx_evt_i,
    input wire logic tx_load_i,
    input wire logic tx_last_bit_i,
    input wire logic card_err_line_i,
    input wire logic err_sample_i,
    output ssef_pkg::ssef_ctrl_s ctrl_o,
    output logic [7:0] rx_data_o,
    output logic rx_halt_o,
    output logic tx_halt_o,
    output logic tx_mp_bit_o
);
    // delay counts, rounded up since they are least times
    localparam int GM0_CYC = (ETU_CYCLES * ssef_pkg::GM0_HALF_ETU + 1) / 2;
    localparam int GM1_CYC = (ETU_CYCLES * ssef_pkg::GM1_HALF_ETU + 1) / 2;
    localparam logic [15:0] GM0_CNT = 16'(GM0_CYC);
    localparam logic [15:0] GM1_CNT = 16'(GM1_CYC);
    localparam logic [15:0] CNT_ONE = 16'h0001;

    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    ssef_pkg::ssef_ctrl_s ctrl_reg;
    logic tx_empty_reg, rx_full_reg, fer_ers_reg, parity_reg;
    logic tx_end_reg, rx_mp_reg, tx_mp_reg;
    logic tx_empty_next, rx_full_next, fer_ers_next, parity_next;
    logic tx_end_next, rx_mp_next, tx_mp_next;
    logic arm_empty_reg, arm_full_reg, arm_fer_reg, arm_par_reg;
    logic [7:0] rx_data_reg;
    logic rx_halt_reg, tx_halt_reg, tx_mp_out_reg;
    logic err_s1_reg, err_s2_reg;
    logic [15:0] cnt_reg;
    logic cnt_busy_reg;

    // bus decode: one wait state, writes land on the completing edge
    wire stat_hit = (paddr_i == ssef_pkg::STATUS_ADDR);
    wire ctrl_hit = (paddr_i == ssef_pkg::CTRL_ADDR);
    wire addr_hit = stat_hit | ctrl_hit;
    wire access = psel_i & penable_i & ~pready_reg;
    wire done = psel_i & penable_i & pready_reg;
    wire wr_stat = done & pwrite_i & stat_hit;
    wire wr_ctrl = done & pwrite_i & ctrl_hit;
    wire rd_stat = done & ~pwrite_i & stat_hit;
    wire ssef_pkg::ssef_ctrl_s ctrl_wval =
        ssef_pkg::ssef_ctrl_s'(pwdata_i[ssef_pkg::CTRL_WIDTH-1:0]);

    // status view; bit 5 belongs to a flag kept elsewhere and reads zero
    wire [7:0] status_view = {tx_empty_reg, rx_full_reg, 1'b0, fer_ers_reg,
                              parity_reg, tx_end_reg, rx_mp_reg, tx_mp_reg};
    wire [31:0] rd_mux = stat_hit ? {24'h00_0000, status_view} :
                         ctrl_hit ? {23'h00_0000, ctrl_reg} : 32'h0000_0000;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= access;
            prdata_reg <= (access & ~pwrite_i) ? rd_mux : 32'h0000_0000;
            pslverr_reg <= access & ~addr_hit;
        end
    end

    // control register; transmitter falling edge seen at the write
    wire te_fall = wr_ctrl & ctrl_reg.transmitter_enable &
                   ~ctrl_wval.transmitter_enable;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_reg <= '0;
        end else if (wr_ctrl) begin
            ctrl_reg <= ctrl_wval;
        end
    end

    // error line is a pin: two flops before anything looks at it
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            err_s1_reg <= 1'b1;
            err_s2_reg <= 1'b1;
        end else begin
            err_s1_reg <= card_err_line_i;
            err_s2_reg <= err_s1_reg;
        end
    end

    // read-then-clear: a flag is armed only when a read returned it as 1
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            arm_empty_reg <= 1'b0;
            arm_full_reg <= 1'b0;
            arm_fer_reg <= 1'b0;
            arm_par_reg <= 1'b0;
        end else if (rd_stat) begin
            arm_empty_reg <= prdata_reg[ssef_pkg::BIT_TX_EMPTY];
            arm_full_reg <= prdata_reg[ssef_pkg::BIT_RX_FULL];
            arm_fer_reg <= prdata_reg[ssef_pkg::BIT_FER_ERS];
            arm_par_reg <= prdata_reg[ssef_pkg::BIT_PARITY];
        end else if (wr_stat | standby_i) begin
            arm_empty_reg <= 1'b0;
            arm_full_reg <= 1'b0;
            arm_fer_reg <= 1'b0;
            arm_par_reg <= 1'b0;
        end
    end

    wire clr_empty = wr_stat & arm_empty_reg & ~pwdata_i[ssef_pkg::BIT_TX_EMPTY];
    wire clr_full = wr_stat & arm_full_reg & ~pwdata_i[ssef_pkg::BIT_RX_FULL];
    wire clr_fer = wr_stat & arm_fer_reg & ~pwdata_i[ssef_pkg::BIT_FER_ERS];
    wire clr_par = wr_stat & arm_par_reg & ~pwdata_i[ssef_pkg::BIT_PARITY];

    // receive stall while the parity flag or, outside card mode, the framing flag stands
    wire card = ctrl_reg.smart_card_select;
    wire halt_now = (fer_ers_reg & ~card) | parity_reg;
    // disabled receiver takes nothing, so framing flag holds outside card mode
    // parity flag held the same way
    wire rx_take = rx_evt_i.valid & ctrl_reg.receiver_enable & ~halt_now;
    wire async_rx = rx_take & ~ctrl_reg.sync_mode;
    // only the first stop bit is looked at
    wire frame_bad = async_rx & ~card & ~rx_evt_i.stop1;
    // parity over data plus parity bit
    wire par_bad = async_rx & ctrl_reg.parity_en &
                   ((^{rx_evt_i.data, rx_evt_i.parity}) != ctrl_reg.parity_odd);
    // error signal sampled low during card transmission
    wire ers_set = card & err_sample_i & ~err_s2_reg;
    // one bit, set source chosen by card select
    wire fer_set = frame_bad | ers_set;

    wire cnt_done = cnt_busy_reg & (cnt_reg == CNT_ONE);
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= 16'h0000;
            cnt_busy_reg <= 1'b0;
        end else if (standby_i) begin
            cnt_busy_reg <= 1'b0;
        end else if (card & tx_last_bit_i) begin
            cnt_reg <= ctrl_reg.guard_mode ? GM1_CNT : GM0_CNT;
            cnt_busy_reg <= 1'b1;
        end else if (cnt_busy_reg) begin
            cnt_reg <= cnt_reg - CNT_ONE;
            cnt_busy_reg <= ~cnt_done;
        end
    end

    // transmit end source switched by card select; transmitter disable sets it in either mode
    wire transmit_end_flag_set = te_fall |
                    (~card & tx_last_bit_i & tx_empty_reg) |
                    (card & cnt_done & tx_empty_reg & ~fer_ers_reg);

    // flag next values; a set beats a same-cycle clear
    always_comb begin
        tx_empty_next = (te_fall | tx_load_i) ? 1'b1 :
                        (clr_empty ? 1'b0 : tx_empty_reg);
        rx_full_next = (rx_take & ~frame_bad & ~par_bad) ? 1'b1 :
                       (clr_full ? 1'b0 : rx_full_reg);
        // transmitter disable does not touch this bit
        fer_ers_next = fer_set ? 1'b1 : (clr_fer ? 1'b0 : fer_ers_reg);
        parity_next = par_bad ? 1'b1 : (clr_par ? 1'b0 : parity_reg);
        // only the empty-flag clear drops transmit end
        tx_end_next = transmit_end_flag_set ? 1'b1 : (clr_empty ? 1'b0 : tx_end_reg);
        rx_mp_next = (async_rx & ctrl_reg.multiproc_en) ? rx_evt_i.mp : rx_mp_reg;
        tx_mp_next = wr_stat ? pwdata_i[ssef_pkg::BIT_TX_MP] : tx_mp_reg;
        if (standby_i) begin
            tx_empty_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_TX_EMPTY];
            rx_full_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_RX_FULL];
            fer_ers_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_FER_ERS];
            parity_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_PARITY];
            tx_end_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_TX_END];
            rx_mp_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_RX_MP];
            tx_mp_next = ssef_pkg::STATUS_RESET[ssef_pkg::BIT_TX_MP];
        end
    end

    // reset value of the status register
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_empty_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_TX_EMPTY];
            rx_full_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_RX_FULL];
            fer_ers_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_FER_ERS];
            parity_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_PARITY];
            tx_end_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_TX_END];
            rx_mp_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_RX_MP];
            tx_mp_reg <= ssef_pkg::STATUS_RESET[ssef_pkg::BIT_TX_MP];
        end else begin
            tx_empty_reg <= tx_empty_next;
            rx_full_reg <= rx_full_next;
            fer_ers_reg <= fer_ers_next;
            parity_reg <= parity_next;
            tx_end_reg <= tx_end_next;
            rx_mp_reg <= rx_mp_next;
            tx_mp_reg <= tx_mp_next;
        end
    end

    // every taken character lands in the data register, even a bad one
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_data_reg <= 8'h00;
        end else if (rx_take) begin
            rx_data_reg <= rx_evt_i.data;
        end
    end

    // halts follow the next flag values so they drop with the clear
    // multiprocessor bit only in async multiprocessor format with tx on
    // written bit goes out with each character
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_halt_reg <= 1'b0;
            tx_halt_reg <= 1'b0;
            tx_mp_out_reg <= 1'b0;
        end else begin
            rx_halt_reg <= (fer_ers_next & ~card) | parity_next;
            tx_halt_reg <= ctrl_reg.sync_mode & ((fer_ers_next & ~card) | parity_next);
            tx_mp_out_reg <= tx_mp_next & ~ctrl_reg.sync_mode &
                             ctrl_reg.multiproc_en & ctrl_reg.transmitter_enable;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign ctrl_o = ctrl_reg;
    assign rx_data_o = rx_data_reg;
    assign rx_halt_o = rx_halt_reg;
    assign tx_halt_o = tx_halt_reg;
    assign tx_mp_bit_o = tx_mp_out_reg;

    // checks run on the block clock and sleep through reset
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_frame_sets_fer: assert property (
        frame_bad & ~standby_i |=> fer_ers_reg)
        else $error("framing error did not set flag");

    a_stop2_ignored: assert property (
        async_rx & ~card & rx_evt_i.stop1 & ~ers_set & ~fer_ers_reg & ~standby_i |=> ~fer_ers_reg)
        else $error("second stop bit raised framing error");

    a_bad_no_full: assert property (
        (frame_bad | par_bad) & ~rx_full_reg & ~standby_i
        |=> ~rx_full_reg && rx_data_reg == $past(rx_evt_i.data))
        else $error("error character set receive full");

    a_halt_blocks: assert property (
        halt_now & rx_evt_i.valid |=> $stable(rx_data_reg))
        else $error("reception continued during error");

    a_card_no_frame: assert property (
        card & rx_take & ~rx_evt_i.stop1 & ~fer_ers_reg & ~ers_set & ~standby_i |=> ~fer_ers_reg)
        else $error("framing checked in card mode");

    a_ers_set: assert property (
        ers_set & ~standby_i |=> fer_ers_reg)
        else $error("low error line not flagged");

    a_clear_needs_read: assert property (
        wr_stat & ~arm_fer_reg & fer_ers_reg & ~standby_i |=> fer_ers_reg)
        else $error("flag cleared without prior read");

    a_parity_sets: assert property (
        par_bad & ~standby_i |=> parity_reg)
        else $error("parity mismatch not flagged");

    a_transmit_end_flag_normal: assert property (
        ~card & tx_last_bit_i & tx_empty_reg & ~standby_i |=> tx_end_reg)
        else $error("transmit end not set");

    a_card_delay: assert property (
        card & tx_last_bit_i & ~ctrl_reg.guard_mode & ~standby_i |=> cnt_reg == GM0_CNT)
        else $error("card end delay wrong");

    a_standby_init: assert property (
        standby_i |=> status_view == ssef_pkg::STATUS_RESET)
        else $error("standby did not initialise status");

    a_mp_gated: assert property (
        ctrl_reg.sync_mode |=> ~tx_mp_bit_o)
        else $error("multiprocessor bit sent in sync mode");

    a_rx_off_fer: assert property (
        ~ctrl_reg.receiver_enable & ~card & ~fer_ers_reg & ~standby_i |=> ~fer_ers_reg)
        else $error("framing flag moved with receiver off");

    a_rx_off_par: assert property (
        ~ctrl_reg.receiver_enable & ~parity_reg & ~standby_i |=> ~parity_reg)
        else $error("parity flag moved with receiver off");

    a_ers_te_off: assert property (
        te_fall & fer_ers_reg & ~standby_i |=> fer_ers_reg)
        else $error("transmitter disable cleared error flag");

    a_par_clear: assert property (
        clr_par & ~par_bad & ~standby_i |=> ~parity_reg)
        else $error("parity flag not cleared");

    a_transmit_end_flag_readonly: assert property (
        wr_stat & ~clr_empty & ~transmit_end_flag_set & ~standby_i |=> tx_end_reg == $past(tx_end_reg))
        else $error("status write changed transmit end");

    a_card_end_late: assert property (
        card & tx_last_bit_i & ~cnt_busy_reg & ~te_fall & ~tx_end_reg & ~standby_i |=> ~tx_end_reg)
        else $error("card transmit end came without delay");

    a_rx_mp_hold: assert property (
        ~ctrl_reg.receiver_enable & ~standby_i |=> $stable(rx_mp_reg))
        else $error("received multiprocessor bit moved");

    a_tx_mp_follow: assert property (
        ~ctrl_reg.sync_mode & ctrl_reg.multiproc_en & ctrl_reg.transmitter_enable
        |=> tx_mp_bit_o == tx_mp_reg)
        else $error("transmit multiprocessor bit not sent");

    // main scenarios reached
    c_frame_err: cover property (frame_bad);
    c_parity_err: cover property (par_bad);
    c_card_end: cover property (card & cnt_done & tx_empty_reg);
    c_clear_fer: cover property (clr_fer);
    c_ers_set: cover property (ers_set);
endmodule
`default_nettype wire

// ---- testbench/ssef_remote_model.sv ----
// remote serial peer: hands over received characters and drives the card error line
`timescale 1ns/100ps
`default_nettype none
module ssef_remote_model (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic send_i,
    input wire ssef_pkg::ssef_rx_s char_i,
    input wire logic err_low_i,
    output ssef_pkg::ssef_rx_s rx_evt_o,
    output logic err_line_o
);
    // one character per send; between characters the fields flip so stale data never matches
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_evt_o <= '0;
        end else if (send_i) begin
            rx_evt_o <= char_i;
        end else begin
            rx_evt_o <= {1'b0, ~rx_evt_o[11:0]};
        end
    end

    // low reports parity error
    // the line has a pull-up, so it idles high whenever the card is not signalling
    assign err_line_o = err_low_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- testbench/test_serial_status_error_flags.sv ----
// self-checking bench for the serial status/error flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module test_serial_status_error_flags;
    // short bit time keeps the card end-of-transmit waits small
    localparam int ETU = 4;
    localparam int GM0_WAIT = (ETU * 5 + 1) / 2;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic standby = 1'b0;
    logic send_req = 1'b0;
    logic err_low = 1'b0;
    logic [2:0] strb = 3'h0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] lfsr = 32'h0001_5e1c;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rx_halt, tx_halt, tx_mp, err_line, rerr, odd, bad;
    logic [7:0] rx_data, st, d;
    ssef_pkg::ssef_rx_s chr = '0;
    ssef_pkg::ssef_rx_s rx_evt;
    ssef_pkg::ssef_ctrl_s ctrl_q;
    int fails = 0;
    int checks_done = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    ssef_status #(.ETU_CYCLES(ETU)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .standby_i(standby), .rx_evt_i(rx_evt),
        .tx_load_i(strb[0]), .tx_last_bit_i(strb[1]), .card_err_line_i(err_line),
        .err_sample_i(strb[2]), .ctrl_o(ctrl_q), .rx_data_o(rx_data), .rx_halt_o(rx_halt),
        .tx_halt_o(tx_halt), .tx_mp_bit_o(tx_mp)
    );

    ssef_remote_model peer_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .send_i(send_req), .char_i(chr),
        .err_low_i(err_low), .rx_evt_o(rx_evt), .err_line_o(err_line)
    );

    // counts and verdict, the single exit of the run
    task end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // parity bit that makes the count of ones match the chosen sense
    function automatic logic good_par(input logic [7:0] v, input logic o);
        return o ? ~^v : ^v;
    endfunction

    // apb transfer; request held until pready is seen, bounded wait
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk_i);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            fails++;
            end_sim();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rs();
        apb(1'b0, ssef_pkg::STATUS_ADDR, 32'h0000_0000);
        st = rdata[7:0];
    endtask

    task ws(input logic [7:0] s);
        apb(1'b1, ssef_pkg::STATUS_ADDR, {24'h00_0000, s});
    endtask

    // control write, then let the registered copy settle
    task wc(input logic [8:0] c);
        apb(1'b1, ssef_pkg::CTRL_ADDR, {23'h00_0000, c});
        repeat (2) @(posedge ref_clk_i);
        `CHK(ctrl_q, c)
    endtask

    // one-cycle pulse on load, last bit or error sample
    task strobe(input logic [2:0] w);
        @(posedge ref_clk_i);
        strb <= w;
        @(posedge ref_clk_i);
        strb <= 3'h0;
    endtask

    task send(input logic [7:0] v, input logic p, input logic s1, input logic s2, input logic mp);
        @(posedge ref_clk_i);
        chr <= {1'b1, v, p, s1, s2, mp};
        send_req <= 1'b1;
        @(posedge ref_clk_i);
        send_req <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    // card end of transmit: clear, load, last bit, then look after w cycles
    task transmit_end_flag(input logic gm, input int w, input logic e);
        wc({1'b1, gm, 7'h01});
        rs();
        ws(8'h00);
        strobe(3'h1);
        strobe(3'h2);
        repeat (w) @(posedge ref_clk_i);
        rs();
        `CHK(st[2], e)
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rs();
        `CHK(st, ssef_pkg::STATUS_RESET)
        apb(1'b0, 12'h008, 32'h0000_0000);
        `CHK(rerr, 1'b1)
        // random characters, four of the twelve with a parity fault
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            d = lfsr[15:8];
            odd = lfsr[0];
            bad = lfsr[1];
            wc(9'h012 | {5'h00, odd, 3'h0});
            send(d, good_par(d, odd) ^ bad, 1'b1, 1'b1, 1'b0);
            rs();
            `CHK(rx_data, d)
            `CHK(st[3], bad)
            `CHK(st[6], ~bad)
            `CHK(rx_halt, bad)
            if (bad) begin
                send(~d, good_par(~d, odd), 1'b1, 1'b1, 1'b0);
                `CHK(rx_data, d)
                wc(9'h010);
                rs();
                `CHK(st[3], 1'b1)
            end
            ws(8'h00);
            rs();
            `CHK({st[3], rx_halt}, 2'h0)
        end
        $display("test parity done");
        wc(9'h006);
        send(8'h5a, 1'b0, 1'b1, 1'b0, 1'b0);
        rs();
        `CHK(st[4], 1'b0)
        ws(8'h00);
        send(8'ha5, 1'b0, 1'b0, 1'b1, 1'b0);
        // a write with no read before it must leave the flag set
        ws(8'h00);
        rs();
        `CHK(st[4], 1'b1)
        `CHK({st[4], st[6]}, 2'h2)
        `CHK(rx_data, 8'ha5)
        `CHK({rx_halt, tx_halt}, 2'h2)
        wc(9'h040);
        rs();
        `CHK(st[4], 1'b1)
        `CHK(tx_halt, 1'b1)
        ws(8'h00);
        $display("test framing done");
        wc(9'h001);
        rs();
        ws(8'h00);
        rs();
        `CHK({st[7], st[2]}, 2'h0)
        strobe(3'h2);
        rs();
        `CHK(st[2], 1'b0)
        strobe(3'h1);
        strobe(3'h2);
        rs();
        `CHK({st[7], st[2]}, 2'h3)
        ws(8'h04);
        rs();
        `CHK(st[2], 1'b0)
        wc(9'h000);
        rs();
        `CHK(st[2], 1'b1)
        $display("test transmit end done");
        wc(9'h023);
        send(8'h3c, 1'b0, 1'b1, 1'b1, 1'b1);
        rs();
        `CHK(st[1], 1'b1)
        wc(9'h021);
        rs();
        `CHK(st[1], 1'b1)
        ws(8'h01);
        repeat (2) @(posedge ref_clk_i);
        `CHK(tx_mp, 1'b1)
        wc(9'h061);
        `CHK(tx_mp, 1'b0)
        wc(9'h001);
        `CHK(tx_mp, 1'b0)
        $display("test multiprocessor done");
        wc(9'h101);
        err_low <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        strobe(3'h4);
        err_low <= 1'b0;
        rs();
        `CHK(st[4], 1'b1)
        wc(9'h100);
        rs();
        `CHK(st[4], 1'b1)
        ws(8'h00);
        rs();
        `CHK(st[4], 1'b0)
        standby <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        standby <= 1'b0;
        rs();
        `CHK(st, ssef_pkg::STATUS_RESET)
        wc(9'h102);
        send(8'h77, 1'b0, 1'b0, 1'b0, 1'b0);
        rs();
        `CHK({st[4], rx_halt}, 2'h0)
        // a read shows the status two edges after its wait, so the first two bracket the set edge and the third lands on it
        transmit_end_flag(1'b0, GM0_WAIT - 3, 1'b0);
        transmit_end_flag(1'b0, GM0_WAIT - 2, 1'b1);
        transmit_end_flag(1'b1, ETU - 2, 1'b1);
        $display("test smart card done");
        end_sim();
    end
endmodule
`default_nettype wire
